/* File: dv/gpc_pin_model.sv */
// External circuitry that resolves each pin wire
`default_nettype none
module gpc_pin_model (
   input wire logic [3:0] pin_out_reg,
   input wire logic [3:0] pin_oe_reg,
   input wire logic [3:0] ext_level,
   output logic [3:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released open-drain pins see the outside source
   assign pin_in = (pin_oe_reg & pin_out_reg) | (~pin_oe_reg & ext_level);
endmodule
`default_nettype wire

/* File: dv/gpc_top_assertions.sv */
// Port checker for the pin block
`default_nettype none
module gpc_top_checker #(
   parameter NUM_PINS = 4,
   parameter AUX_WORD_W = 32,
   parameter AUX_HALF_DIV = 4
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [23:0] reg_rdata_reg,
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic [NUM_PINS-1:0] pin_out_reg,
   input wire logic [NUM_PINS-1:0] pin_oe_reg,
   input wire logic [AUX_WORD_W-1:0] aux_word,
   input wire logic aux_word_valid,
   input wire logic aux_word_last,
   input wire logic aux_word_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic w6 = reg_wr && reg_addr == 8'h06;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   rst_idle_a: assert property ($rose(rst_b) |-> pin_oe_reg == 0)
      else $error("pin driven after reset");
   pp_drive_a: assert property (
      w6 && reg_wdata[15:14] == 2'b10 ##1 !reg_wr
      |-> ##1 pin_oe_reg[3] && pin_out_reg[3] == $past(reg_wdata[13], 2))
      else $error("pin3 push-pull wrong");
   od_drive_a: assert property (
      w6 && reg_wdata[15:14] == 2'b11 ##1 !reg_wr
      |-> ##1 !pin_out_reg[3] && pin_oe_reg[3] != $past(reg_wdata[13], 2))
      else $error("pin3 open drain wrong");
   p2_drive_a: assert property (
      w6 && reg_wdata[16:10] == 7'h02 ##1 !reg_wr
      |-> ##1 pin_oe_reg[2] && pin_out_reg[2] == $past(reg_wdata[9], 2))
      else $error("pin2 push-pull wrong");
   aux_pins_a: assert property (
      w6 && reg_wdata[16] ##1 !reg_wr |-> ##1 pin_oe_reg[2:0] == 3'b111)
      else $error("aux pins not driven");
   rdy_off_a: assert property (
      w6 && !reg_wdata[16] ##1 !reg_wr |-> ##[1:3] !aux_word_ready)
      else $error("ready while aux off");
   rd_zero_a: assert property (!$past(reg_rd) |-> reg_rdata_reg == 0)
      else $error("read data outside read");
   resv_zero_a: assert property (!reg_rdata_reg[17] && !reg_rdata_reg[23:19])
      else $error("reserved bits set");
   cover property (w6 && reg_wdata[16]);
   cover property (aux_word_valid && aux_word_ready && !aux_word_last);
   cover property ($rose(pin_out_reg[0]) && pin_oe_reg[0]);
endmodule
bind gpc_top gpc_top_checker #(.NUM_PINS(NUM_PINS), .AUX_WORD_W(AUX_WORD_W),
   .AUX_HALF_DIV(AUX_HALF_DIV)) i_gpc_top_checker (.mclk, .rst_b, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_reg, .pin_in, .pin_out_reg,
   .pin_oe_reg, .aux_word, .aux_word_valid, .aux_word_last, .aux_word_ready);
`default_nettype wire

/* File: dv/tb_gpio_pin_control_with_aux_spi.sv */
// Self-checking bench for the pin block
`default_nettype none
module tb_gpio_pin_control_with_aux_spi;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst_b = 0, wr_s = 0, rd_s = 0, vld = 0, lst = 0, rdy;
   logic [7:0] addr = 0;
   logic [23:0] wd = 0, rdata, v, r;
   logic [3:0] pout, poe, pin, ext = 0;
   logic [31:0] word = 0;
   int mismatches = 0, num_checks = 0, rises = 0;
   always #5 mclk = ~mclk;
   always @(posedge pout[0]) rises++;
   gpc_top i_gpc_top (.mclk, .rst_b, .reg_addr(addr), .reg_wdata(wd),
      .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata_reg(rdata), .pin_in(pin),
      .pin_out_reg(pout), .pin_oe_reg(poe), .aux_word(word),
      .aux_word_valid(vld), .aux_word_last(lst), .aux_word_ready(rdy));
   gpc_pin_model i_gpc_pin_model (.pin_out_reg(pout), .pin_oe_reg(poe),
      .ext_level(ext), .pin_in(pin));
   task automatic chk(string n, logic [23:0] seen, logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [23:0] d);
      @(posedge mclk);
      wr_s <= 1;
      addr <= a;
      wd <= d;
      @(posedge mclk);
      wr_s <= 0;
   endtask
   task automatic rd(logic [7:0] a, output logic [23:0] d);
      @(posedge mclk);
      rd_s <= 1;
      addr <= a;
      @(posedge mclk);
      rd_s <= 0;
      #1 d = rdata;
   endtask
   // Sampled bits only show in input mode, and never on stream pins
   function automatic logic [23:0] exp_rd(logic [23:0] c, logic [3:0] e);
      logic [23:0] x;
      x = c & 24'h05eeee;
      for (int i = 0; i < 4; i++)
         if (c[4*i+3 -: 2] == 2'b01 && !(c[16] && i < 3)) x[4*i] = e[i];
      return x;
   endfunction
   function automatic logic [7:0] exp_pin(logic [23:0] c);
      logic [3:0] oe, o;
      for (int i = 0; i < 4; i++) begin
         oe[i] = c[4*i+3] & ~(c[4*i+2] & c[4*i+1]);
         o[i] = c[4*i+1] & ~c[4*i+2];
      end
      if (c[16]) begin
         oe[2:0] = 3'b111;
         o[2:0] = 3'b001;
      end
      return {oe, o & oe};
   endfunction
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'hb752ab57));
      repeat (12) @(posedge mclk);
      rst_b <= 1;
      rd(8'h06, r);
      chk("reset read", r, 24'h000000);
      wr(8'h07, 24'hffffff);
      rd(8'h07, r);
      chk("unmapped read", r, 24'h000000);
      for (int k = 0; k < 40; k++) begin
         v = k == 0 ? 24'hffffff : 24'($urandom);
         r = 24'($urandom);
         @(posedge mclk);
         ext <= r[3:0];
         wr(8'h06, v);
         repeat (6) @(posedge mclk);
         r = {16'h0, poe, pout & poe};
         chk("pins", r, {16'h0, exp_pin(v)});
         rd(8'h06, r);
         chk("read", r, exp_rd(v, ext));
      end
      for (int f = 0; f < 2; f++) begin
         wr(8'h06, {5'h0, f[0], 2'b01, 16'h0});
         repeat (4) @(posedge mclk);
         rises = 0;
         for (int w = 0; w < 2; w++) begin
            word <= w == 0 ? 32'h80000001 : $urandom;
            lst <= w[0];
            vld <= 1;
            do @(posedge mclk); while (rdy !== 1'b1);
            vld <= 0;
            for (int b = 31; b >= 0; b--) begin
               @(posedge pout[1]);
               chk("serial bit", {23'h0, pout[2]}, {23'h0, word[b]});
               chk("select", {23'h0, pout[0]}, 24'h0);
            end
         end
         repeat (20) @(posedge mclk);
         chk("select rises", rises[23:0], f ? 24'h2 : 24'h1);
      end
      wr(8'h06, 24'h000000);
      repeat (4) @(posedge mclk);
      chk("ready off", {23'h0, rdy}, 24'h0);
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: verilog/gpc_aux_port.v */
// Serial streamer for the auxiliary sample port on pins 0 to 2
`default_nettype none
`include "gpc_map.vh"

module gpc_aux_port #(
   parameter WORD_W = `GPC_AUX_WORD_W,
   parameter HALF_DIV = `GPC_AUX_HALF_DIV
) (
   input wire mclk,
   input wire rst_b,
   input wire enable,
   input wire word_framing,
   input wire [WORD_W-1:0] word_data,
   input wire word_valid,
   input wire word_last,
   output reg word_ready_reg,
   output reg sclk_reg,
   output reg sdo_reg,
   output reg cs_b_reg
);
   localparam ST_IDLE = 2'b00;
   localparam ST_SHIFT = 2'b01;
   localparam ST_GAP = 2'b10;
   localparam CW = (WORD_W > HALF_DIV) ? $clog2(WORD_W + 1) :
                   $clog2(HALF_DIV + 1);
   localparam [CW-1:0] BITS_LAST = WORD_W - 1;
   localparam [CW-1:0] DIV_LAST = HALF_DIV - 1;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [WORD_W-1:0] shift_reg;
   reg [CW-1:0] bit_reg;
   reg [CW-1:0] div_reg;
   reg last_reg;
   wire take = word_valid && word_ready_reg;
   wire tick = (div_reg == DIV_LAST);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take)
               state_next = ST_SHIFT;
         end
         ST_SHIFT: begin
            if (tick && sclk_reg && bit_reg == BITS_LAST)
               state_next = (word_framing || last_reg) ? ST_GAP : ST_IDLE;
         end
         ST_GAP: begin
            if (tick)
               state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (!enable)
         state_next = ST_IDLE;
   end

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         shift_reg <= {WORD_W{1'b0}};
         bit_reg <= {CW{1'b0}};
         div_reg <= {CW{1'b0}};
         last_reg <= 1'b0;
         word_ready_reg <= 1'b0;
         sclk_reg <= 1'b0;
         sdo_reg <= 1'b0;
         cs_b_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         word_ready_reg <= enable && (state_next == ST_IDLE) && !take;
         div_reg <= (tick || state_reg == ST_IDLE) ? {CW{1'b0}} :
                    div_reg + 1'b1;
         if (!enable) begin
            // Disabling mid-word abandons it; chip select releases at once
            sclk_reg <= 1'b0;
            sdo_reg <= 1'b0;
            cs_b_reg <= 1'b1;
            last_reg <= 1'b0;
         end else if (state_reg == ST_IDLE && take) begin
            shift_reg <= {word_data[WORD_W-2:0], 1'b0};
            sdo_reg <= word_data[WORD_W-1];
            last_reg <= word_last;
            bit_reg <= {CW{1'b0}};
            sclk_reg <= 1'b0;
            cs_b_reg <= 1'b0;
         end else if (state_reg == ST_SHIFT && tick) begin
            sclk_reg <= !sclk_reg;
            // Data changes on the falling edge, so the far end samples on rise
            if (sclk_reg) begin
               if (bit_reg == BITS_LAST) begin
                  // Word framing drops select per word, else per frame
                  if (word_framing || last_reg)
                     cs_b_reg <= 1'b1;
               end else begin
                  sdo_reg <= shift_reg[WORD_W-1];
                  shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
                  bit_reg <= bit_reg + 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/gpc_map.vh */
// Register map, field positions and timing constants for the pin block
`ifndef GPC_MAP_VH
`define GPC_MAP_VH

`define GPC_ADDR_W 8
`define GPC_DATA_W 24
`define GPC_PIN_CONTROL_ADDR 8'h06
`define GPC_PIN_CONTROL_RESET 24'h000000

// Per-pin nibble: state [3:2], drive value [1], sampled value [0]
`define GPC_NUM_PINS 4
`define GPC_PIN_STRIDE 4
`define GPC_STATE_LSB 2
`define GPC_DRIVE_BIT 1
`define GPC_SAMPLED_BIT 0
`define GPC_AUX_PINS 3

`define GPC_AUX_ENABLE_BIT 16
`define GPC_AUX_FRAMING_BIT 18

// Pin state encoding
`define GPC_ST_HIGHZ 2'b00
`define GPC_ST_INPUT 2'b01
`define GPC_ST_PUSHPULL 2'b10
`define GPC_ST_OPENDRAIN 2'b11

// Auxiliary port
`define GPC_AUX_RATE_KHZ 128
`define GPC_CLK_MHZ 100
`define GPC_AUX_WORD_W 32
`define GPC_AUX_HALF_DIV 4

`endif

/* File: verilog/gpc_map_note_unused.v */
// Intentionally empty compilation unit
`default_nettype none
`default_nettype wire

/* File: verilog/gpc_top.v */
// Four-pin general-purpose port with register access and auxiliary stream
//
// Implementation choices: the register offsets and strobed register access.
`default_nettype none
`include "gpc_map.vh"

module gpc_top #(
   parameter NUM_PINS = `GPC_NUM_PINS,
   parameter AUX_WORD_W = `GPC_AUX_WORD_W,
   parameter AUX_HALF_DIV = `GPC_AUX_HALF_DIV
) (
   input wire mclk,
   input wire rst_b,
   input wire [`GPC_ADDR_W-1:0] reg_addr,
   input wire [`GPC_DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`GPC_DATA_W-1:0] reg_rdata_reg,
   input wire [NUM_PINS-1:0] pin_in,
   output reg [NUM_PINS-1:0] pin_out_reg,
   output reg [NUM_PINS-1:0] pin_oe_reg,
   input wire [AUX_WORD_W-1:0] aux_word,
   input wire aux_word_valid,
   input wire aux_word_last,
   output wire aux_word_ready
);
   // Returns {output enable, output level} for one pin
   function [1:0] pin_drive;
      input [1:0] st;
      input val;
      begin
         // Open drain never drives high, so a shared wire is never fought
         case (st)
            `GPC_ST_PUSHPULL: pin_drive = {1'b1, val};
            `GPC_ST_OPENDRAIN: pin_drive = {!val, 1'b0};
            default: pin_drive = 2'b00;
         endcase
      end
   endfunction

   // Position of pin n's state field inside the control word
   function integer state_pos;
      input integer n;
      begin
         state_pos = `GPC_PIN_STRIDE*n + `GPC_STATE_LSB;
      end
   endfunction

   // Position of pin n's drive level
   function integer drive_pos;
      input integer n;
      begin
         drive_pos = `GPC_PIN_STRIDE*n + `GPC_DRIVE_BIT;
      end
   endfunction

   // Position of pin n's read-only sampled level
   function integer sampled_pos;
      input integer n;
      begin
         sampled_pos = `GPC_PIN_STRIDE*n + `GPC_SAMPLED_BIT;
      end
   endfunction

   reg [2*NUM_PINS-1:0] pin_state_reg;
   reg [NUM_PINS-1:0] drive_reg;
   reg [NUM_PINS-1:0] sampled_reg;
   reg [NUM_PINS-1:0] sampled_next;
   reg [NUM_PINS-1:0] sync1_reg;
   reg [NUM_PINS-1:0] sync2_reg;
   reg aux_port_enable_reg;
   reg aux_port_word_framing_reg;
   reg [NUM_PINS-1:0] out_next;
   reg [NUM_PINS-1:0] oe_next;
   reg [`GPC_DATA_W-1:0] rd_next;
   reg [1:0] drv;
   wire aux_sclk;
   wire aux_sdo;
   wire aux_port_chip_select_b;
   // Only one word is mapped; every other address is ignored
   wire hit = (reg_addr == `GPC_PIN_CONTROL_ADDR);
   // One loop counter per process, so no variable has two drivers
   integer i;
   integer j;
   integer k;

   // Stream serialiser; its three pins are merged in below
   gpc_aux_port #(
      .WORD_W(AUX_WORD_W),
      .HALF_DIV(AUX_HALF_DIV)
   ) i_gpc_aux_port (
      .mclk(mclk),
      .rst_b(rst_b),
      .enable(aux_port_enable_reg),
      .word_framing(aux_port_word_framing_reg),
      .word_data(aux_word),
      .word_valid(aux_word_valid),
      .word_last(aux_word_last),
      .word_ready_reg(aux_word_ready),
      .sclk_reg(aux_sclk),
      .sdo_reg(aux_sdo),
      .cs_b_reg(aux_port_chip_select_b)
   );

   // Pin fields; sampled bits are read-only and never written
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_state_reg <= {2*NUM_PINS{1'b0}};
         drive_reg <= {NUM_PINS{1'b0}};
      end else if (reg_wr && hit) begin
         for (i = 0; i < NUM_PINS; i = i + 1) begin
            // Pin 3 at [15:12], pin 2 [11:8], pin 1 [7:4], pin 0 [3:0]
            pin_state_reg[2*i +: 2] <= reg_wdata[state_pos(i) +: 2];
            drive_reg[i] <= reg_wdata[drive_pos(i)];
         end
      end
   end

   // Stream controls share the strobe but live apart from the pin fields
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         aux_port_enable_reg <= 1'b0;
         aux_port_word_framing_reg <= 1'b0;
      end else if (reg_wr && hit) begin
         aux_port_enable_reg <= reg_wdata[`GPC_AUX_ENABLE_BIT];
         aux_port_word_framing_reg <=
            reg_wdata[`GPC_AUX_FRAMING_BIT];
      end
   end

   // Pins arrive unsynchronised; only the second stage is looked at
   // The first stage may settle late, so nothing else reads it
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= {NUM_PINS{1'b0}};
         sync2_reg <= {NUM_PINS{1'b0}};
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Pin drive and sampling, with pins 0 to 2 taken over by the stream
   always @* begin
      out_next = {NUM_PINS{1'b0}};
      oe_next = {NUM_PINS{1'b0}};
      sampled_next = {NUM_PINS{1'b0}};
      drv = 2'b00;
      for (j = 0; j < NUM_PINS; j = j + 1) begin
         drv = pin_drive(pin_state_reg[2*j +: 2], drive_reg[j]);
         oe_next[j] = drv[1];
         out_next[j] = drv[0];
         // Outside input mode the bit reads low rather than a stale level
         if (pin_state_reg[2*j +: 2] == `GPC_ST_INPUT)
            sampled_next[j] = sync2_reg[j];
      end
      // Select, clock and data are all push-pull while the stream runs
      if (aux_port_enable_reg) begin
         // Pin 3 is left on its own fields above
         oe_next[`GPC_AUX_PINS-1:0] = {`GPC_AUX_PINS{1'b1}};
         out_next[0] = aux_port_chip_select_b;
         out_next[1] = aux_sclk;
         out_next[2] = aux_sdo;
         sampled_next[`GPC_AUX_PINS-1:0] = {`GPC_AUX_PINS{1'b0}};
      end
   end

   // Registering the pins keeps decode glitches off the wires
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out_reg <= {NUM_PINS{1'b0}};
         pin_oe_reg <= {NUM_PINS{1'b0}};
         sampled_reg <= {NUM_PINS{1'b0}};
      end else begin
         pin_out_reg <= out_next;
         pin_oe_reg <= oe_next;
         sampled_reg <= sampled_next;
      end
   end

   // Readback; reserved bits and unmapped addresses read as zero
   always @* begin
      rd_next = `GPC_PIN_CONTROL_RESET;
      if (hit) begin
         // State and drive fields of pins 0 to 2 stay readable while the stream owns them; their sampled bits read zero
         for (k = 0; k < NUM_PINS; k = k + 1) begin
            rd_next[state_pos(k) +: 2] = pin_state_reg[2*k +: 2];
            rd_next[drive_pos(k)] = drive_reg[k];
            rd_next[sampled_pos(k)] = sampled_reg[k];
         end
         rd_next[`GPC_AUX_ENABLE_BIT] = aux_port_enable_reg;
         rd_next[`GPC_AUX_FRAMING_BIT] = aux_port_word_framing_reg;
      end
   end

   // Read data is only meaningful the cycle after the strobe; held as zero
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         reg_rdata_reg <= {`GPC_DATA_W{1'b0}};
      else if (reg_rd)
         reg_rdata_reg <= rd_next;
      else
         reg_rdata_reg <= {`GPC_DATA_W{1'b0}};
   end
endmodule
`default_nettype wire
